// ===== hw/plp_backup_conv.sv
// Backup step-down converter setpoint, limits and protection
`timescale 1ns/1ns
`default_nettype none
module plp_backup_conv
  import plp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  plp_bk_if.conv   bk
);

  typedef struct packed {
    logic run;
    logic full_duty;
    logic uv_flag;
    logic stop;
  } plp_bk_st_t;

  plp_bk_st_t st_reg;
  plp_bk_st_t st_next;

  logic [15:0] setpoint_mv;
  logic [15:0] uv_mv;
  logic [15:0] ov_mv;
  logic [15:0] limit_ma;
  logic [31:0] oc_prod;
  logic [15:0] oc_ma;
  logic        uv;
  logic        ov;
  logic        lockout;
  logic        oc;

  always_comb begin
    setpoint_mv = PLP_VOUT_BASE_MV + PLP_VOUT_STEP_MV * {9'h000, bk.vout_code};
    if (setpoint_mv > PLP_VOUT_MAX_MV) begin
      setpoint_mv = PLP_VOUT_MAX_MV;
    end
    uv_mv    = plp_pct(setpoint_mv, bk.uv_sel ? PLP_UV_PCT_HI : PLP_UV_PCT_LO);
    ov_mv    = plp_pct(setpoint_mv, PLP_OV_PCT);
    limit_ma = PLP_BK_LIM_BASE_MA + PLP_STEP_1A_MA * {13'h0000, bk.limit_code};
    // Trip at the stated fraction of the limit
    oc_prod  = {16'h0000, limit_ma} * {16'h0000, PLP_BK_OC_NUM};
    oc_prod  = oc_prod / {16'h0000, PLP_BK_OC_DEN};
    oc_ma    = oc_prod[15:0];
    uv       = bk.bout_mv < uv_mv;
    ov       = bk.bout_mv > ov_mv;
    lockout  = bk.storage_mv < PLP_STORAGE_LOCKOUT_LEVEL_MV;
    oc       = bk.sw_ma > oc_ma;
  end

  always_comb begin
    st_next           = st_reg;
    st_next.uv_flag   = bk.enable & uv;
    // Masked undervoltage keeps running; only the other faults stop it
    st_next.stop      = bk.enable & (lockout | ov | oc | (uv & !bk.ng_mask));
    st_next.run       = bk.enable & !st_next.stop;
    st_next.full_duty = st_next.run & bk.ng_mask & uv
                      & (bk.storage_mv < setpoint_mv);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bk.run       = st_reg.run;
  assign bk.full_duty = st_reg.full_duty;
  assign bk.uv_flag   = st_reg.uv_flag;
  assign bk.stop      = st_reg.stop;

endmodule
`default_nettype wire

// ===== hw/plp_bk_if.sv
// Interface between the sequencer and the backup converter controller
`timescale 1ns/1ns
`default_nettype none
interface plp_bk_if;
  logic        enable;
  logic [6:0]  vout_code;
  logic        uv_sel;
  logic        ng_mask;
  logic [2:0]  limit_code;
  logic [15:0] storage_mv;
  logic [15:0] bout_mv;
  logic [15:0] sw_ma;
  logic        run;
  logic        full_duty;
  logic        uv_flag;
  logic        stop;

  modport ctrl (
    output enable, vout_code, uv_sel, ng_mask, limit_code, storage_mv, bout_mv, sw_ma,
    input  run, full_duty, uv_flag, stop
  );
  modport conv (
    input  enable, vout_code, uv_sel, ng_mask, limit_code, storage_mv, bout_mv, sw_ma,
    output run, full_duty, uv_flag, stop
  );
endinterface
`default_nettype wire

// ===== hw/plp_ctrl.sv
// Power-loss protection supervisory control
//
// Notes on behaviour
// - Four-bit switch limit code: 1.5A,2A..8A; upper set gives 9A..12A, capped.
// - Over limit the switch limits linearly; after 10us of it, switch off.
// - Input-to-bus difference above 560mV turns the switch off at once.
// - Every protective switch turn-off from normal state enters backup mode.
// - In startup, current over 90% of limit: switch off, restart softstart.
// - Short-circuit code picks 6.5/10.5/14.5/18.5A; reaching it trips immediately to backup.
// - Function 00: pin low in backup, released otherwise.
// - Function 01: low in softstart, high once storage regulated, low below 95%.
// - Function 11: released only with input in window and no backup.
// - Writing function code 10 is refused; field keeps old value.
// - Keep-on bit clear disables converter; backup entry then goes straight to reset.
// - Discharge enabled and converter forced off: turn on 50mA sink while in reset state.
// - Seven-bit output code: 2.5V plus 100mV steps, capped at 13.2V.
// - Converter stops on storage lockout 2.8V, output undervoltage or overvoltage.
// - Output undervoltage threshold selectable at 60% or 70% of setpoint.
// - Output undervoltage sets not-good flag and moves to reset state.
// - Masked not-good: no reset; converter runs full duty when storage drops.
// - Output above 110% of setpoint is overvoltage; converter stops.
// - Three-bit converter limit code: 3A to 10A in 1A steps.
// - Converter switch current above 22.5% of the limit shuts it down.
// - On backup entry the storage boost stops and runs as step-down.
`timescale 1ns/1ns
`default_nettype none
module plp_ctrl
  import plp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register access
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Configuration bits
  input  wire logic [3:0]  switch_limit_code,
  input  wire logic        backup_conv_keep_on,
  input  wire logic        bus_discharge_en,
  input  wire logic        backup_uv_sel,
  input  wire logic        backup_not_good_mask,
  input  wire logic [2:0]  backup_limit_code,
  // Analog comparators, asynchronous
  input  wire logic        input_under_thr,
  input  wire logic        input_over_thr,
  input  wire logic        vdiff_high,
  input  wire logic        storage_good_raw,
  input  wire logic        softstart_done,
  // Measurements
  input  wire logic [15:0] switch_current_ma,
  input  wire logic [15:0] storage_node_mv,
  input  wire logic [15:0] backup_out_mv,
  input  wire logic [15:0] backup_sw_ma,
  // Controls to the analog stages
  output logic             input_switch_on,
  output logic             switch_linear_limit,
  output logic             softstart_restart,
  output logic             backup_mode,
  output logic             storage_stage_buck,
  output logic             backup_conv_en,
  output logic             backup_full_duty,
  output logic             discharge_sink_en,
  output logic             backup_not_good_flag,
  // Open-drain indicator
  output logic             power_loss_flag_pin_o,
  output logic             power_loss_flag_pin_oe
);

  localparam int NSYNC = 5;
  localparam int S_UNDER = 0;
  localparam int S_OVER  = 1;
  localparam int S_VDIFF = 2;
  localparam int S_STRGD = 3;
  localparam int S_SSDON = 4;

  typedef struct packed {
    plp_state_t       state;
    logic [7:0]       lim_cnt;
    logic             switch_on;
    logic             linear_limit;
    logic             ss_restart;
    logic             backup;
    logic             storage_buck;
    logic             conv_en;
    logic             discharge;
    logic             pin_oe;
    logic [1:0]       func_sel;
    logic [1:0]       sc_sel;
    logic [6:0]       vout_code;
    logic [7:0]       rdata;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [15:0]      cur_q;
    logic             not_good;
    logic             full_duty;
  } plp_ctrl_st_t;

  plp_ctrl_st_t st_reg;
  plp_ctrl_st_t st_next;

  plp_bk_if bk ();

  plp_backup_conv u_conv (
    .ref_clk (ref_clk),
    .reset   (reset),
    .bk      (bk)
  );

  assign bk.enable     = st_reg.conv_en;
  assign bk.vout_code  = st_reg.vout_code;
  assign bk.uv_sel     = backup_uv_sel;
  assign bk.ng_mask    = backup_not_good_mask;
  assign bk.limit_code = backup_limit_code;
  assign bk.storage_mv = storage_node_mv;
  assign bk.bout_mv    = backup_out_mv;
  assign bk.sw_ma      = backup_sw_ma;

  ////////////////////////////////////////
  // Decoded thresholds and synchronized comparators

  logic [15:0] sw_limit_ma;
  logic [15:0] sc_thr_ma;
  logic [19:0] cur_x10;
  logic [19:0] lim_x9;
  logic        over_limit;
  logic        ss_trip;
  logic        sc_trip;
  logic        input_ok;
  logic        vdiff_trip;
  logic        storage_good;
  logic        ss_done;

  always_comb begin
    sw_limit_ma  = plp_sw_limit_ma(switch_limit_code);
    sc_thr_ma    = PLP_SC_BASE_MA + PLP_SC_STEP_MA * {14'h0000, st_reg.sc_sel};
    cur_x10      = {4'h0, st_reg.cur_q} * {15'h0000, PLP_SS_TRIP_DEN};
    lim_x9       = {4'h0, sw_limit_ma} * {15'h0000, PLP_SS_TRIP_NUM};
    over_limit   = st_reg.cur_q > sw_limit_ma;
    ss_trip      = cur_x10 > lim_x9;
    sc_trip      = st_reg.cur_q >= sc_thr_ma;
    // Second stage only
    input_ok     = !st_reg.sync2[S_UNDER] & !st_reg.sync2[S_OVER];
    vdiff_trip   = st_reg.sync2[S_VDIFF];
    storage_good = st_reg.sync2[S_STRGD];
    ss_done      = st_reg.sync2[S_SSDON];
  end

  ////////////////////////////////////////
  // Next state

  logic trip;

  always_comb begin
    st_next            = st_reg;
    trip               = 1'b0;
    st_next.sync1      = {softstart_done, storage_good_raw, vdiff_high,
                          input_over_thr, input_under_thr};
    st_next.sync2      = st_reg.sync1;
    st_next.cur_q      = switch_current_ma;
    st_next.ss_restart = 1'b0;
    st_next.not_good   = bk.uv_flag;
    st_next.full_duty  = bk.full_duty;

    // Register writes and reads
    if (reg_wr) begin
      case (reg_addr)
        PLP_ADDR_FLAG_CFG: begin
          if (reg_wdata[PLP_FUNC_LSB +: 2] != PLP_FN_INVALID) begin
            st_next.func_sel = reg_wdata[PLP_FUNC_LSB +: 2];
          end
        end
        PLP_ADDR_SW_CFG: st_next.sc_sel = reg_wdata[PLP_SC_LSB +: 2];
        PLP_ADDR_BK_VOUT: st_next.vout_code = reg_wdata[PLP_VOUT_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        PLP_ADDR_FLAG_CFG: begin
          st_next.rdata = 8'h00;
          st_next.rdata[PLP_FUNC_LSB +: 2] = st_reg.func_sel;
          st_next.rdata[PLP_NG_BIT] = st_reg.not_good;
        end
        PLP_ADDR_SW_CFG: begin
          st_next.rdata = 8'h00;
          st_next.rdata[PLP_SC_LSB +: 2] = st_reg.sc_sel;
        end
        PLP_ADDR_BK_VOUT: st_next.rdata = {1'b0, st_reg.vout_code};
        default: st_next.rdata = 8'h00;
      endcase
    end

    case (st_reg.state)
      PLP_ST_POR: begin
        st_next.switch_on    = 1'b0;
        st_next.linear_limit = 1'b0;
        st_next.lim_cnt      = 8'h00;
        st_next.conv_en      = 1'b0;
        st_next.storage_buck = 1'b0;
        if (input_ok) begin
          st_next.state      = PLP_ST_SOFTSTART;
          st_next.backup     = 1'b0;
          st_next.switch_on  = 1'b1;
          st_next.ss_restart = 1'b1;
        end
      end
      PLP_ST_SOFTSTART: begin
        st_next.switch_on = 1'b1;
        if (!input_ok) begin
          st_next.state     = PLP_ST_POR;
          st_next.switch_on = 1'b0;
        end else if (ss_trip && st_reg.switch_on && !st_reg.ss_restart) begin
          // Current seen before a restart is stale
          st_next.switch_on  = 1'b0;
          st_next.ss_restart = 1'b1;
        end else if (ss_done) begin
          st_next.state = PLP_ST_NORMAL;
        end
      end
      PLP_ST_NORMAL: begin
        st_next.linear_limit = over_limit;
        if (over_limit) begin
          st_next.lim_cnt = st_reg.lim_cnt + 8'h01;
        end else begin
          st_next.lim_cnt = 8'h00;
        end
        if (over_limit && (st_reg.lim_cnt >= PLP_LIMIT_CYCLES - 8'h01)) begin
          trip = 1'b1;
        end
        if (vdiff_trip || sc_trip || !input_ok) begin
          trip = 1'b1;
        end
        if (trip) begin
          st_next.switch_on    = 1'b0;
          st_next.linear_limit = 1'b0;
          st_next.lim_cnt      = 8'h00;
          st_next.backup       = 1'b1;
          st_next.storage_buck = 1'b1;
          if (backup_conv_keep_on) begin
            st_next.state   = PLP_ST_BACKUP;
            st_next.conv_en = 1'b1;
          end else begin
            st_next.state   = PLP_ST_POR;
            st_next.conv_en = 1'b0;
          end
        end
      end
      PLP_ST_BACKUP: begin
        st_next.switch_on    = 1'b0;
        st_next.storage_buck = 1'b1;
        st_next.conv_en      = backup_conv_keep_on;
        // Any converter stop ends backup
        if (!backup_conv_keep_on || bk.stop) begin
          st_next.state   = PLP_ST_POR;
          st_next.conv_en = 1'b0;
        end
      end
      default: begin
        st_next.state = PLP_ST_POR;
      end
    endcase

    st_next.discharge = bus_discharge_en & !backup_conv_keep_on
                      & (st_next.state == PLP_ST_POR);

    // Indicator pin, low when enabled
    case (st_reg.func_sel)
      PLP_FN_NOT_IN_BACKUP: st_next.pin_oe = st_next.backup;
      PLP_FN_STORAGE_GOOD: begin
        st_next.pin_oe = (st_next.state == PLP_ST_POR)
                       || (st_next.state == PLP_ST_SOFTSTART)
                       || !storage_good;
      end
      PLP_FN_INPUT_OK: st_next.pin_oe = !input_ok || st_next.backup;
      default: st_next.pin_oe = 1'b1;
    endcase
  end

  ////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.state     <= PLP_ST_POR;
      st_reg.func_sel  <= PLP_FUNC_RST;
      st_reg.sc_sel    <= PLP_SC_RST;
      st_reg.vout_code <= PLP_VOUT_RST;
      st_reg.sync1     <= {NSYNC{1'b1}} & 5'h03;
      st_reg.sync2     <= {NSYNC{1'b1}} & 5'h03;
      st_reg.pin_oe    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata              = st_reg.rdata;
  assign input_switch_on        = st_reg.switch_on;
  assign switch_linear_limit    = st_reg.linear_limit;
  assign softstart_restart      = st_reg.ss_restart;
  assign backup_mode            = st_reg.backup;
  assign storage_stage_buck     = st_reg.storage_buck;
  assign backup_conv_en         = st_reg.conv_en;
  assign backup_full_duty       = st_reg.full_duty;
  assign discharge_sink_en      = st_reg.discharge;
  assign backup_not_good_flag   = st_reg.not_good;
  assign power_loss_flag_pin_o  = 1'b0;
  assign power_loss_flag_pin_oe = st_reg.pin_oe;

endmodule
`default_nettype wire

// ===== hw/plp_pkg.sv
// Package: constants, types, decode functions
package plp_pkg;

  // Register offsets
  localparam logic [7:0] PLP_ADDR_FLAG_CFG = 8'h26;
  localparam logic [7:0] PLP_ADDR_SW_CFG   = 8'h2c;
  localparam logic [7:0] PLP_ADDR_BK_VOUT  = 8'hcb;

  // Field positions
  localparam int PLP_FUNC_LSB = 0;
  localparam int PLP_NG_BIT   = 7;
  localparam int PLP_SC_LSB   = 2;
  localparam int PLP_VOUT_W   = 7;

  // Reset values
  localparam logic [1:0] PLP_FUNC_RST = 2'h0;
  localparam logic [1:0] PLP_SC_RST   = 2'h0;
  localparam logic [6:0] PLP_VOUT_RST = 7'h00;

  // Indicator function codes
  localparam logic [1:0] PLP_FN_NOT_IN_BACKUP = 2'h0;
  localparam logic [1:0] PLP_FN_STORAGE_GOOD  = 2'h1;
  localparam logic [1:0] PLP_FN_INVALID       = 2'h2;
  localparam logic [1:0] PLP_FN_INPUT_OK      = 2'h3;

  // Input switch current limits, mA
  localparam logic [15:0] PLP_SW_LIM_MIN_MA  = 16'h05dc;  // 1.5A
  localparam logic [15:0] PLP_SW_LIM_LO_BASE = 16'h03e8;  // 1A + 1A per step
  localparam logic [15:0] PLP_SW_LIM_HI_BASE = 16'h2328;  // 9A
  localparam logic [15:0] PLP_SW_LIM_MAX_MA  = 16'h2ee0;  // 12A
  localparam logic [15:0] PLP_STEP_1A_MA     = 16'h03e8;
  localparam logic [4:0]  PLP_SS_TRIP_NUM    = 5'h09;     // 90 percent
  localparam logic [4:0]  PLP_SS_TRIP_DEN    = 5'h0a;

  // Short-circuit thresholds: 6.5A plus 4A per code
  localparam logic [15:0] PLP_SC_BASE_MA = 16'h1964;
  localparam logic [15:0] PLP_SC_STEP_MA = 16'h0fa0;

  // Backup output: 2.5V plus 100mV per code
  localparam logic [15:0] PLP_VOUT_BASE_MV = 16'h09c4;
  localparam logic [15:0] PLP_VOUT_STEP_MV = 16'h0064;
  localparam logic [15:0] PLP_VOUT_MAX_MV  = 16'h3390;
  localparam logic [15:0] PLP_STORAGE_LOCKOUT_LEVEL_MV  = 16'h0af0;    // 2.8V
  localparam logic [7:0]  PLP_UV_PCT_LO    = 8'h3c;       // 60
  localparam logic [7:0]  PLP_UV_PCT_HI    = 8'h46;       // 70
  localparam logic [7:0]  PLP_OV_PCT       = 8'h6e;       // 110
  localparam logic [7:0]  PLP_PCT_DEN      = 8'h64;       // 100
  localparam logic [15:0] PLP_BK_LIM_BASE_MA = 16'h0bb8;  // 3A
  localparam logic [15:0] PLP_BK_OC_NUM      = 16'h00e1;  // 22.5 percent
  localparam logic [15:0] PLP_BK_OC_DEN      = 16'h03e8;

  // Timing
  localparam int PLP_CLK_PERIOD_NS = 50;
  localparam int PLP_LIMIT_TIME_NS = 10000;
  localparam int PLP_LIMIT_CYCLES_I = PLP_LIMIT_TIME_NS / PLP_CLK_PERIOD_NS;
  localparam logic [7:0] PLP_LIMIT_CYCLES = PLP_LIMIT_CYCLES_I[7:0];

  typedef enum logic [1:0] {
    PLP_ST_POR,
    PLP_ST_SOFTSTART,
    PLP_ST_NORMAL,
    PLP_ST_BACKUP
  } plp_state_t;

  // Switch limit in mA
  function automatic logic [15:0] plp_sw_limit_ma(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    if (!code[3]) begin
      if (code[2:0] == 3'h0) begin
        v = PLP_SW_LIM_MIN_MA;
      end else begin
        v = PLP_SW_LIM_LO_BASE + PLP_STEP_1A_MA * {13'h0000, code[2:0]};
      end
    end else begin
      v = PLP_SW_LIM_HI_BASE + PLP_STEP_1A_MA * {13'h0000, code[2:0]};
      if (v > PLP_SW_LIM_MAX_MA) begin
        v = PLP_SW_LIM_MAX_MA;
      end
    end
    return v;
  endfunction

  // Scale a value by pct/100
  function automatic logic [15:0] plp_pct(input logic [15:0] val, input logic [7:0] pct);
    logic [23:0] p;
    p = {8'h00, val} * {16'h0000, pct};
    p = p / {16'h0000, PLP_PCT_DEN};
    return p[15:0];
  endfunction

endpackage

// ===== tb/plp_ctrl_chk.sv
// Checker: port-level properties
`timescale 1ns/1ns
`default_nettype none
module plp_ctrl_chk
  import plp_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       backup_conv_keep_on,
  input wire logic       bus_discharge_en,
  input wire logic       input_under_thr,
  input wire logic       input_over_thr,
  input wire logic       vdiff_high,
  input wire logic       storage_good_raw,
  input wire logic       softstart_done,
  input wire logic       input_switch_on,
  input wire logic       switch_linear_limit,
  input wire logic       softstart_restart,
  input wire logic       backup_mode,
  input wire logic       storage_stage_buck,
  input wire logic       backup_conv_en,
  input wire logic       discharge_sink_en,
  input wire logic       power_loss_flag_pin_oe
);
  logic [1:0] fn_seen;
  logic [7:0] lim_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Shadow of the function field
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fn_seen <= PLP_FUNC_RST;
      lim_cnt <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == PLP_ADDR_FLAG_CFG && reg_wdata[1:0] != PLP_FN_INVALID) begin
        fn_seen <= reg_wdata[1:0];
      end
      lim_cnt <= (input_switch_on && switch_linear_limit) ? lim_cnt + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////
  sequence s_entry;
    $rose(backup_mode);
  endsequence
  sequence s_drop_high;
    (input_switch_on && softstart_done && vdiff_high)[*4];
  endsequence
  property p_rd_func;
    reg_rd && reg_addr == PLP_ADDR_FLAG_CFG |=> reg_rdata[1:0] != PLP_FN_INVALID;
  endproperty
  property p_lim_time;
    lim_cnt < 8'hcb;
  endproperty
  property p_vdiff;
    s_drop_high |-> ##[0:4] !input_switch_on;
  endproperty
  property p_entry;
    s_entry |-> !input_switch_on && storage_stage_buck;
  endproperty
  property p_keep_on;
    s_entry |-> backup_conv_en == $past(backup_conv_keep_on);
  endproperty
  property p_discharge;
    discharge_sink_en |-> $past(bus_discharge_en) && !$past(backup_conv_keep_on);
  endproperty
  property p_fn_backup;
    (fn_seen == PLP_FN_NOT_IN_BACKUP && backup_mode)[*3] |-> power_loss_flag_pin_oe;
  endproperty
  property p_fn_release;
    (fn_seen == PLP_FN_NOT_IN_BACKUP && !backup_mode)[*3] |-> !power_loss_flag_pin_oe;
  endproperty
  property p_fn_input;
    (fn_seen == PLP_FN_INPUT_OK && (input_under_thr || input_over_thr))[*4]
      |-> power_loss_flag_pin_oe;
  endproperty
  property p_fn_storage;
    (fn_seen == PLP_FN_STORAGE_GOOD && !storage_good_raw)[*4] |-> power_loss_flag_pin_oe;
  endproperty
  property p_restart;
    softstart_restart |=> !softstart_restart;
  endproperty
  a_rd_func: assert property (p_rd_func) else $error("refused code held");
  a_lim_time: assert property (p_lim_time) else $error("limiting too long");
  a_vdiff: assert property (p_vdiff) else $error("switch on, vdiff");
  a_entry: assert property (p_entry) else $error("entry with switch on");
  a_keep_on: assert property (p_keep_on) else $error("enable wrong at entry");
  a_discharge: assert property (p_discharge) else $error("sink on without cause");
  a_fn_backup: assert property (p_fn_backup) else $error("pin released in backup");
  a_fn_release: assert property (p_fn_release) else $error("pin held outside backup");
  a_fn_input: assert property (p_fn_input) else $error("pin released, input out");
  a_fn_storage: assert property (p_fn_storage) else $error("pin released, storage low");
  a_restart: assert property (p_restart) else $error("restart not a pulse");
endmodule
bind plp_ctrl plp_ctrl_chk i_plp_ctrl_chk (.*);
`default_nettype wire

// ===== tb/plp_host_model.sv
// Host side of the indicator pin: pull-up resolved line as the processor sees it
`timescale 1ns/1ns
`default_nettype none
module plp_host_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_high
);
  // Board pull-up wins once the device lets go
  assign pin_high = pin_oe ? pin_o : 1'b1;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Testbench for the protection control
`timescale 1ns/1ns
`default_nettype none
module tb
  import plp_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  switch_limit_code = 4'h3;
  logic [2:0]  backup_limit_code = 3'h0;
  logic        backup_conv_keep_on = 1'b1, bus_discharge_en = 1'b1;
  logic        backup_uv_sel = 1'b0, backup_not_good_mask = 1'b0;
  logic        input_under_thr = 1'b0, input_over_thr = 1'b0, vdiff_high = 1'b0;
  logic        storage_good_raw = 1'b1, softstart_done = 1'b0;
  logic [15:0] switch_current_ma = 16'h0000, backup_sw_ma = 16'h0000, thr;
  logic [15:0] storage_node_mv = 16'h2ee0, backup_out_mv = 16'h09c4;
  logic        input_switch_on, switch_linear_limit, softstart_restart, backup_mode;
  logic        storage_stage_buck, backup_conv_en, backup_full_duty, discharge_sink_en;
  logic        backup_not_good_flag, power_loss_flag_pin_o, power_loss_flag_pin_oe, pin_high;
  logic [7:0]  addrs [3] = '{PLP_ADDR_FLAG_CFG, PLP_ADDR_SW_CFG, PLP_ADDR_BK_VOUT};
  int          err_total = 0, tests_run = 0, i;
  always #25 ref_clk = ~ref_clk;
  plp_ctrl i_plp_ctrl (.*);
  plp_host_model i_plp_host_model (
    .pin_o(power_loss_flag_pin_o), .pin_oe(power_loss_flag_pin_oe), .pin_high
  );
  ////////////////////////////////////////
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // Bounded wait; timeout ends the run
  task automatic wait_sw(input logic lvl, input int lim);
    int n;
    n = 0;
    while (input_switch_on !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (input_switch_on !== lvl) begin
      err_total++;
      finish_test();
    end
  endtask
  // Lockout first drops a running converter
  task automatic start_up();
    @(posedge ref_clk);
    storage_node_mv <= 16'h0aef;
    switch_current_ma <= 16'h0000;
    vdiff_high <= 1'b0;
    input_over_thr <= 1'b0;
    softstart_done <= 1'b0;
    tick(4);
    @(posedge ref_clk);
    storage_node_mv <= 16'h2ee0;
    wait_sw(1'b1, 20);
    @(posedge ref_clk);
    softstart_done <= 1'b1;
    tick(6);
    chk("backup_mode", backup_mode, 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (addrs[k]) begin
      rd(addrs[k], d);
      chk("reset_value", d, 8'h00);
    end
    wr(8'h10, 8'hff);
    rd(8'h10, d);
    chk("unmapped", d, 8'h00);
    wr(PLP_ADDR_FLAG_CFG, 8'h01);
    rd(PLP_ADDR_FLAG_CFG, d);
    chk("func", d, 8'h01);
    wr(PLP_ADDR_FLAG_CFG, 8'h02);
    rd(PLP_ADDR_FLAG_CFG, d);
    chk("func", d, 8'h01);
    wr(PLP_ADDR_FLAG_CFG, 8'h03);
    wr(PLP_ADDR_SW_CFG, 8'hff);
    rd(PLP_ADDR_SW_CFG, d);
    chk("sc_sel", d, 8'h0c);
    wr(PLP_ADDR_BK_VOUT, 8'hff);
    rd(PLP_ADDR_BK_VOUT, d);
    chk("vout", d, 8'h7f);
    wr(PLP_ADDR_BK_VOUT, 8'h00);
    chk("pin_ok", pin_high, 1'b1);
    @(posedge ref_clk);
    input_under_thr <= 1'b1;
    tick(5);
    chk("pin_under", pin_high, 1'b0);
    @(posedge ref_clk);
    input_under_thr <= 1'b0;
    wr(PLP_ADDR_FLAG_CFG, 8'h01);
    wait_sw(1'b1, 10);
    tick(3);
    chk("pin_softstart", pin_high, 1'b0);
    @(posedge ref_clk);
    switch_current_ma <= 16'h0e11;
    wait_sw(1'b0, 6);
    chk("restart", softstart_restart, 1'b1);
    @(posedge ref_clk);
    switch_current_ma <= 16'h0e10;
    wait_sw(1'b1, 6);
    tick(6);
    chk("ss_at_90pct", input_switch_on, 1'b1);
    @(posedge ref_clk);
    softstart_done <= 1'b1;
    tick(5);
    chk("pin_storage", pin_high, 1'b1);
    @(posedge ref_clk);
    storage_good_raw <= 1'b0;
    tick(5);
    chk("pin_storage_low", pin_high, 1'b0);
    @(posedge ref_clk);
    storage_good_raw <= 1'b1;
    switch_current_ma <= 16'h0fa0;
    tick(10);
    chk("linear_at_limit", switch_linear_limit, 1'b0);
    @(posedge ref_clk);
    switch_current_ma <= 16'h0fa1;
    tick(5);
    chk("linear", switch_linear_limit, 1'b1);
    tick(185);
    chk("still_on", input_switch_on, 1'b1);
    wait_sw(1'b0, 20);
    chk("backup_mode", backup_mode, 1'b1);
    chk("conv_en", backup_conv_en, 1'b1);
    chk("stage_buck", storage_stage_buck, 1'b1);
    wr(PLP_ADDR_FLAG_CFG, 8'h00);
    tick(2);
    chk("pin_backup", pin_high, 1'b0);
    @(posedge ref_clk);
    storage_node_mv <= 16'h0aef;
    tick(5);
    chk("conv_lockout", backup_conv_en, 1'b0);
    @(posedge ref_clk);
    backup_conv_keep_on <= 1'b0;
    start_up();
    chk("pin_normal", pin_high, 1'b1);
    @(posedge ref_clk);
    vdiff_high <= 1'b1;
    // Window fault keeps reset state
    @(posedge ref_clk);
    input_over_thr <= 1'b1;
    wait_sw(1'b0, 6);
    chk("backup_mode", backup_mode, 1'b1);
    chk("conv_off", backup_conv_en, 1'b0);
    tick(3);
    chk("sink", discharge_sink_en, 1'b1);
    chk("pin_backup", pin_high, 1'b0);
    @(posedge ref_clk);
    backup_conv_keep_on <= 1'b1;
    switch_limit_code <= 4'hb;
    for (i = 0; i < 4; i++) begin
      thr = 16'h1964 + 16'h0fa0 * i[15:0];
      wr(PLP_ADDR_SW_CFG, {4'h0, i[1:0], 2'h0});
      start_up();
      @(posedge ref_clk);
      switch_current_ma <= thr - 16'h0001;
      tick(6);
      chk("sc_below", input_switch_on, 1'b1);
      @(posedge ref_clk);
      switch_current_ma <= thr;
      wait_sw(1'b0, 6);
      chk("sc_backup", backup_mode, 1'b1);
    end
    wr(PLP_ADDR_BK_VOUT, 8'h7f);
    // Flag is gated by converter enable but lags it, so it is still set after the converter turns off
    tick(2);
    chk("not_good", backup_not_good_flag, 1'b1);
    chk("conv_uv_off", backup_conv_en, 1'b0);
    rd(PLP_ADDR_FLAG_CFG, d);
    chk("not_good_bit", d[7], 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
